// ---- core/lsg_pkg.sv ----
// ==========================================================
// Shared constants of the link self-test global control
package lsg_pkg;
   // Port count and the ports that exist (bit 1 has no port)
   localparam int         PORTS      = 8;
   localparam logic [7:0] PORT_MASK  = 8'hfd;
   // Register indices; byte address is four times the index
   localparam int         IDX_W      = 10;
   localparam logic [9:0] IDX_DONE   = 10'h394;
   localparam logic [9:0] IDX_ERR    = 10'h395;
   localparam logic [9:0] IDX_START  = 10'h398;
   localparam logic [9:0] IDX_ISTAT  = 10'h3a0;
   localparam logic [9:0] IDX_IMASK  = 10'h3a1;
   // Index field inside the byte address
   localparam int         IDX_LSB    = 2;
   // Values after reset
   localparam logic [7:0]  RST_START = 8'h00;
   localparam logic [7:0]  RST_DONE  = 8'h00;
   localparam logic [7:0]  RST_ERR   = 8'h00;
   localparam logic [15:0] RST_IRQ   = 16'h0000;
   // Interrupt field layout: done events low, fault events high
   localparam int         IRQ_W      = 16;
   localparam int         IRQ_FAULT  = 8;
   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic       HRESP_OKAY    = 1'b0;
endpackage : lsg_pkg

// ---- core/lsg_reg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Register access carrier between bus front end and registers
interface lsg_reg_if;
   logic        wr_en;    // Write applies at this edge
   logic [9:0]  wr_idx;   // Register index of the write
   logic [31:0] wr_data;  // Write data
   logic        rd_en;    // Read address phase taken
   logic [9:0]  rd_idx;   // Register index of the read
   // Bus front end drives, register file listens
   modport front (output wr_en, wr_idx, wr_data, rd_en, rd_idx);
   modport regs  (input  wr_en, wr_idx, wr_data, rd_en, rd_idx);
endinterface : lsg_reg_if
`default_nettype wire

// ---- core/lsg_ahb_front.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// AHB-Lite address phase capture, zero wait states
module lsg_ahb_front #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              reset_in,
   // Bus address and data phase
   input  wire logic              hsel_in,
   input  wire logic [ADDR_W-1:0] haddr_in,
   input  wire logic [1:0]        htrans_in,
   input  wire logic              hwrite_in,
   input  wire logic              hready_in,
   input  wire logic [31:0]       hwdata_in,
   // Register side
   lsg_reg_if.front               reg_if
);
   logic       take;        // Address phase accepted
   logic       wr_q, wr_d;  // Write waits for its data phase
   logic [9:0] idx_q, idx_d;
   logic [9:0] idx_now;     // Index of the current address

   // ==========================================================
   // Decode
   always_comb begin
      take    = hsel_in && hready_in && htrans_in[1];
      idx_now = haddr_in[lsg_pkg::IDX_LSB +: lsg_pkg::IDX_W];
      wr_d    = take && hwrite_in;
      idx_d   = take ? idx_now : idx_q;
   end

   // Pending write capture
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         wr_q  <= 1'b0;
         idx_q <= 10'h000;
      end else begin
         wr_q  <= wr_d;
         idx_q <= idx_d;
      end
   end

   assign reg_if.wr_en   = wr_q;
   assign reg_if.wr_idx  = idx_q;
   assign reg_if.wr_data = hwdata_in;
   assign reg_if.rd_en   = take && !hwrite_in;
   assign reg_if.rd_idx  = idx_now;
endmodule : lsg_ahb_front
`default_nettype wire

// ---- core/lsg_sticky_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Sticky flags: hardware sets, write of one clears, set wins
module lsg_sticky_bank #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clock_in,
   input  wire logic         reset_in,
   // Events and clears
   input  wire logic [W-1:0] set_in,
   input  wire logic [W-1:0] clr_in,
   // Flag state
   output logic      [W-1:0] flags_out,
   output logic      [W-1:0] flags_d_out
);
   logic [W-1:0] flags_q;  // Sticky flags

   // Next value; an event in the clear cycle is kept
   always_comb begin
      flags_d_out = (flags_q & ~clr_in) | set_in;
   end

   // Flag register
   always_ff @(posedge clock_in) begin
      if (reset_in) flags_q <= '0;
      else          flags_q <= flags_d_out;
   end

   assign flags_out = flags_q;
endmodule : lsg_sticky_bank
`default_nettype wire

// ---- core/lsg_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsg_top #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              reset_in,
   // AHB-Lite slave
   input  wire logic              hsel_in,
   input  wire logic [ADDR_W-1:0] haddr_in,
   input  wire logic [1:0]        htrans_in,
   input  wire logic              hwrite_in,
   input  wire logic [2:0]        hsize_in,
   input  wire logic              hready_in,
   input  wire logic [31:0]       hwdata_in,
   output logic      [31:0]       hrdata_out,
   output logic                   hreadyout_out,
   output logic                   hresp_out,
   // Per-port self-test engines
   output logic      [7:0]        go_port_out,
   input  wire logic [7:0]        engine_done_in,
   input  wire logic [7:0]        engine_fault_in,
   // Interrupt
   output logic                   irq_out
);
   // ==========================================================
   // Elaboration checks
   generate
      // Index field must fit inside the byte address
      if (ADDR_W < 12) begin : g_bad_addr
         $error("ADDR_W must cover the register indices");
      end
   endgenerate

   // ==========================================================
   // Decoding helpers
   // Write hit on one register index
   function automatic logic wr_hit(input logic en, input logic [9:0] idx,
                                   input logic [9:0] want);
      wr_hit = en && (idx == want);
   endfunction

   // ==========================================================
   // Internal signals
   lsg_reg_if reg_if ();                  // Bus to registers
   logic [7:0]  start_q, start_d;          // Start bits
   logic [7:0]  done_q, done_d;            // Completion bits
   logic [7:0]  go_q, go_d;                // Launch pulses
   logic [15:0] imask_q, imask_d;          // Interrupt mask
   logic [31:0] rdata_q, rdata_d;          // Read data
   logic        irq_q, irq_d;              // Interrupt level
   logic        ready_q;                   // Bus ready
   logic [7:0]  start_hit;                 // Ports launched now
   logic [7:0]  fault_set;                 // Fault events
   logic [7:0]  fault_clr;                 // Fault clears
   logic [7:0]  done_set;                  // Completion events
   logic [7:0]  err_q, err_d;              // Error flags
   logic [15:0] istat_q, istat_d;          // Interrupt status
   logic [15:0] istat_clr;                 // Interrupt clears

   // ==========================================================
   // Bus front end
   // Address phase captured here; a write applies one cycle later
   lsg_ahb_front #(.ADDR_W(ADDR_W)) u_front (
      .clock_in  (clock_in),
      .reset_in  (reset_in),
      .hsel_in   (hsel_in),
      .haddr_in  (haddr_in),
      .htrans_in (htrans_in),
      .hwrite_in (hwrite_in),
      .hready_in (hready_in),
      .hwdata_in (hwdata_in),
      .reg_if    (reg_if)
   );

   // ==========================================================
   // Start bits and launch pulses
   always_comb begin
      start_hit = 8'h00;
      start_d   = start_q;
      // One write launches every selected port in one cycle
      if (wr_hit(reg_if.wr_en, reg_if.wr_idx, lsg_pkg::IDX_START)) begin
         start_d   = reg_if.wr_data[7:0] & lsg_pkg::PORT_MASK;
         start_hit = reg_if.wr_data[7:0] & lsg_pkg::PORT_MASK;
      end
      // A zero only stores; nothing is sent to the engine
      go_d = start_hit;
   end

   // Start register and pulse register
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         start_q <= lsg_pkg::RST_START;
         go_q    <= 8'h00;
      end else begin
         // Pulses last exactly one cycle
         start_q <= start_d;
         go_q    <= go_d;
      end
   end

   // ==========================================================
   // Completion status
   always_comb begin
      // Finishes from ports that exist only
      done_set = engine_done_in & lsg_pkg::PORT_MASK;
      // A new start wins over a stale finish of the previous run
      done_d   = (done_q | done_set) & ~start_hit;
   end

   // Completion register
   always_ff @(posedge clock_in) begin
      if (reset_in) done_q <= lsg_pkg::RST_DONE;
      else          done_q <= done_d;
   end

   // ==========================================================
   // Error flags
   always_comb begin
      fault_set = engine_fault_in & lsg_pkg::PORT_MASK;
      fault_clr = 8'h00;
      // Ones written to the error register clear flags
      if (wr_hit(reg_if.wr_en, reg_if.wr_idx, lsg_pkg::IDX_ERR)) begin
         fault_clr = reg_if.wr_data[7:0];
      end
   end

   // Sticky error bank
   lsg_sticky_bank #(.W(lsg_pkg::PORTS)) u_err (
      .clock_in    (clock_in),
      .reset_in    (reset_in),
      .set_in      (fault_set),
      .clr_in      (fault_clr),
      .flags_out   (err_q),
      .flags_d_out (err_d)
   );

   // ==========================================================
   // Interrupt status, mask and level
   always_comb begin
      istat_clr = 16'h0000;
      imask_d   = imask_q;
      if (wr_hit(reg_if.wr_en, reg_if.wr_idx, lsg_pkg::IDX_ISTAT)) begin
         istat_clr = reg_if.wr_data[15:0];
      end
      // Mask takes the written word
      if (wr_hit(reg_if.wr_en, reg_if.wr_idx, lsg_pkg::IDX_IMASK)) begin
         imask_d = reg_if.wr_data[15:0];
      end
      // Level from next values, so it moves with the flags
      irq_d = |(istat_d & imask_d);
   end

   // Sticky interrupt bank
   lsg_sticky_bank #(.W(lsg_pkg::IRQ_W)) u_istat (
      .clock_in    (clock_in),
      .reset_in    (reset_in),
      .set_in      ({fault_set, done_set & ~start_hit}),
      .clr_in      (istat_clr),
      .flags_out   (istat_q),
      .flags_d_out (istat_d)
   );

   // Mask and interrupt registers
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         imask_q <= lsg_pkg::RST_IRQ;
         irq_q   <= 1'b0;
      end else begin
         imask_q <= imask_d;
         irq_q   <= irq_d;
      end
   end

   // ==========================================================
   // Read data; next values so a write just before is seen
   always_comb begin
      rdata_d = rdata_q;
      if (reg_if.rd_en) begin
         unique case (reg_if.rd_idx)
            lsg_pkg::IDX_START: rdata_d = {24'h000000, start_d};
            lsg_pkg::IDX_DONE:  rdata_d = {24'h000000, done_d};
            lsg_pkg::IDX_ERR:   rdata_d = {24'h000000, err_d};
            lsg_pkg::IDX_ISTAT: rdata_d = {16'h0000, istat_d};
            lsg_pkg::IDX_IMASK: rdata_d = {16'h0000, imask_d};
            // Unmapped addresses read zero
            default:            rdata_d = 32'h00000000;
         endcase
      end
   end

   // Read data and ready registers
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         rdata_q <= 32'h00000000;
         ready_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         // Zero wait states from the first edge after reset
         ready_q <= 1'b1;
      end
   end

   // ==========================================================
   // Outputs
   assign hrdata_out    = rdata_q;
   assign hreadyout_out = ready_q;
   // Response is always OKAY
   assign hresp_out     = lsg_pkg::HRESP_OKAY;
   assign go_port_out   = go_q;
   assign irq_out       = irq_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);

   logic st_wr, er_wr;  // Writes to start and error registers
   assign st_wr = wr_hit(reg_if.wr_en, reg_if.wr_idx, lsg_pkg::IDX_START);
   assign er_wr = wr_hit(reg_if.wr_en, reg_if.wr_idx, lsg_pkg::IDX_ERR);

   // Start write with bit k set, then its launch pulse one cycle later
   sequence s_launch(int k);
      st_wr && reg_if.wr_data[k] ##1 go_port_out[k];
   endsequence

   // Reserved bit 1 of start, done and error never holds a one
   property p_reserved;
      start_q[1] == 1'b0 && done_q[1] == 1'b0 && err_q[1] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   // Every selected port pulses in the same cycle
   property p_together;
      st_wr |=> go_port_out == ($past(reg_if.wr_data[7:0]) & 8'hfd);
   endproperty
   a_together: assert property (p_together) else $error("ports not launched together");

   // Start bits store the write; the pulse ends after one cycle
   property p_start_store;
      st_wr |=> start_q == ($past(reg_if.wr_data[7:0]) & 8'hfd) ##1 (go_port_out == 8'h00 || $past(st_wr));
   endproperty
   a_start_store: assert property (p_start_store) else $error("start bits wrong");

   // No done in the cycle after the launch pulse unless a finish came with it
   property p_running;
      s_launch(2) ##0 !engine_done_in[2] |=> !done_q[2];
   endproperty
   a_running: assert property (p_running) else $error("done while running");

   // A finish sets done one edge later
   property p_finish;
      engine_done_in[7] && !(st_wr && reg_if.wr_data[7]) |=> done_q[7] && irq_q == |(istat_q & imask_q);
   endproperty
   a_finish: assert property (p_finish) else $error("finish not reported");

   // A start clears done and launches the engine
   property p_clear_on_start;
      st_wr && reg_if.wr_data[0] |=> !done_q[0] && go_port_out[0];
   endproperty
   a_clear_on_start: assert property (p_clear_on_start) else $error("done not cleared");

   // A fault stays set until a one is written to it
   property p_fault_sticky;
      engine_fault_in[2] |=> err_q[2] ##1 (err_q[2] || $past(er_wr && reg_if.wr_data[2]));
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag lost");

   // Write of one clears, write of zero keeps
   property p_w1c;
      er_wr && !engine_fault_in[2] |=> err_q[2] == ($past(err_q[2]) && !$past(reg_if.wr_data[2]));
   endproperty
   a_w1c: assert property (p_w1c) else $error("error clear wrong");

   // A zero start bit launches and clears nothing
   property p_zero_start;
      st_wr && !reg_if.wr_data[5] && !engine_done_in[5] && !engine_fault_in[5]
         |=> !go_port_out[5] && $stable(done_q[5]) && $stable(err_q[5]);
   endproperty
   a_zero_start: assert property (p_zero_start) else $error("zero write had effect");

   // Done rises only on an engine finish
   property p_done_source;
      $rose(done_q[6]) |-> $past(engine_done_in[6]);
   endproperty
   a_done_source: assert property (p_done_source) else $error("done without finish");

   // A fault flag rises only on an engine error
   property p_fault_source;
      $rose(err_q[0]) |-> $past(engine_fault_in[0]);
   endproperty
   a_fault_source: assert property (p_fault_source) else $error("fault without error");
endmodule : lsg_top
`default_nettype wire

// ---- bench/lsg_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the link self-test global control
module lsg_top_test;
   logic        clock_in, reset_in, hsel, hwrite, rd_v, hready, hreadyout, hresp, irq;
   logic [11:0] haddr;                       // Byte address
   logic [1:0]  htrans;                      // Transfer type
   logic [31:0] hwdata, hrdata;              // Bus data
   logic [7:0]  go, e_done, e_fault;         // Engine link
   logic [31:0] rq[$];                       // Expected read data
   logic [7:0]  gq[$];                       // Expected start pulses
   int          n_mismatch, checks, seed, i;
   logic [7:0]  s, d, done_m;                // Random start, done and done model
   logic [31:0] r;                           // Read data sink
   localparam logic [11:0] A_DONE = {lsg_pkg::IDX_DONE, 2'b00};
   localparam logic [11:0] A_ERR  = {lsg_pkg::IDX_ERR, 2'b00};
   localparam logic [11:0] A_GO   = {lsg_pkg::IDX_START, 2'b00};
   localparam logic [11:0] A_IST  = {lsg_pkg::IDX_ISTAT, 2'b00};
   localparam logic [11:0] A_IMK  = {lsg_pkg::IDX_IMASK, 2'b00};
   // One slave, so its ready is the bus ready
   assign hready = hreadyout;
   // ==========================================================
   // Design under test
   lsg_top #(.ADDR_W(12)) u_dut (
      .clock_in(clock_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready),
      .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
      .go_port_out(go), .engine_done_in(e_done), .engine_fault_in(e_fault), .irq_out(irq));
   // ==========================================================
   // Compare and report
   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic finish_test();
      $display("mismatches=%0d checks=%0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================================
   // One single transfer, called right after a rising edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] dat);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= lsg_pkg::HTRANS_NONSEQ;
      do @(posedge clock_in); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= dat;
      rd_v   <= !wr;
      do @(posedge clock_in); while (hready !== 1'b1);
      r = hrdata;
      rd_v <= 1'b0;
   endtask
   // Read with its expected value noted first
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   // Write; a start write notes the pulse it must raise
   task automatic wr(input logic [11:0] a, input logic [31:0] dat);
      if (a == A_GO && (dat[7:0] & lsg_pkg::PORT_MASK) != 8'h00) begin
         gq.push_back(dat[7:0] & lsg_pkg::PORT_MASK);
      end
      bus(1'b1, a, dat);
   endtask
   // One-cycle engine pulses
   task automatic eng(input logic [7:0] dn, input logic [7:0] ft);
      e_done  <= dn;
      e_fault <= ft;
      @(posedge clock_in);
      e_done  <= 8'h00;
      e_fault <= 8'h00;
   endtask
   // Interrupt level once the edge has settled
   task automatic irqchk(input logic e);
      #1;
      cmp({31'h0, irq}, {31'h0, e});
      @(posedge clock_in);
   endtask
   // ==========================================================
   // Monitor: oldest note against each result
   always @(posedge clock_in) begin
      if (rd_v && hready === 1'b1) begin
         cmp({31'h0, hresp}, 32'h0);
         if (rq.size() == 0) cmp(hrdata, 32'hffffffff);
         else cmp(hrdata, rq.pop_front());
      end
      if (!reset_in && go !== 8'h00) begin
         if (gq.size() == 0) cmp({24'h0, go}, 32'h0);
         else cmp({24'h0, go}, {24'h0, gq.pop_front()});
      end
   end
   // ==========================================================
   // Clock and watchdog
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end
   // ==========================================================
   // Main sequence
   initial begin
      n_mismatch = 0; checks = 0; seed = 7365;
      reset_in = 1'b1; hsel = 1'b0; hwrite = 1'b0; rd_v = 1'b0; haddr = 12'h0;
      htrans = 2'h0; hwdata = 32'h0; e_done = 8'h00; e_fault = 8'h00;
      repeat (10) @(posedge clock_in);
      reset_in <= 1'b0;
      // Reset values and an unmapped place
      rd(A_DONE, 32'h0);
      rd(A_ERR, 32'h0);
      rd(A_GO, 32'h0);
      rd(A_IST, 32'h0);
      rd(A_IMK, 32'h0);
      rd(12'h000, 32'h0);
      // All ports at once, reserved bit stays clear
      wr(A_GO, 32'hffffffff);
      rd(A_GO, 32'hfd);
      rd(A_DONE, 32'h0);
      eng(8'hff, 8'h07);
      rd(A_DONE, 32'hfd);
      rd(A_ERR, 32'h05);
      // Clear by one only
      wr(A_ERR, 32'h04);
      rd(A_ERR, 32'h01);
      wr(A_ERR, 32'h00);
      rd(A_ERR, 32'h01);
      // Writing zero leaves done and error bits unchanged
      wr(A_GO, 32'h0);
      rd(A_DONE, 32'hfd);
      rd(A_ERR, 32'h01);
      // Restart one port clears its done bit
      wr(A_GO, 32'h80);
      rd(A_DONE, 32'h7d);
      // Interrupt: raise, mask and clear
      rd(A_IST, 32'h05fd);
      irqchk(1'b0);
      wr(A_IMK, 32'h0100);
      irqchk(1'b1);
      rd(A_IMK, 32'h0100);
      wr(A_IST, 32'h0100);
      irqchk(1'b0);
      eng(8'h00, 8'h04);
      irqchk(1'b0);
      eng(8'h00, 8'h01);
      irqchk(1'b1);
      rd(A_ERR, 32'h05);
      // Random starts and completions against a small model
      done_m = 8'h7d;
      for (i = 0; i < 8; i++) begin
         s = 8'($random(seed));
         d = 8'($random(seed));
         wr(A_GO, {24'h0, s});
         done_m = done_m & ~s;
         rd(A_DONE, {24'h0, done_m});
         eng(d, 8'h00);
         done_m = done_m | (d & lsg_pkg::PORT_MASK);
         rd(A_DONE, {24'h0, done_m});
         rd(A_GO, {24'h0, s & lsg_pkg::PORT_MASK});
      end
      repeat (3) @(posedge clock_in);
      cmp(rq.size() + gq.size(), 32'h0);
      finish_test();
   end
endmodule // lsg_top_test
`default_nettype wire
